// ### rtl/bor_defines.svh
// Constants of the blit operand register bank: offsets, field ranges, masks.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef BOR_DEFINES_SVH
`define BOR_DEFINES_SVH

// ==========================================================
// Register byte offsets (8-bit address, one word each)
`define BOR_A_TILE_LAST 8'h7c
`define BOR_A_SRC_BASE  8'h80
`define BOR_A_DST_BASE  8'h84
`define BOR_A_SRC_SIZE  8'h88
`define BOR_A_DST_SIZE  8'h8c
`define BOR_A_SRC_POS   8'h90
`define BOR_A_DST_POS   8'h94
`define BOR_A_COMMAND   8'h98
`define BOR_A_SRC_FMT   8'h9c
`define BOR_A_TILE_CFG  8'ha0

// ==========================================================
// Writable-bit masks; reserved bits read zero
`define BOR_M_BASE      32'h80ffffff
`define BOR_M_SIZE      32'h1fff1fff
`define BOR_M_POS       32'h1fff1fff
`define BOR_M_COMMAND   32'hffffff0f
`define BOR_M_SRC_FMT   32'h00ff3fff
`define BOR_M_TILE_CFG  32'h00000001
`define BOR_RESET_WORD  32'h00000000

// ==========================================================
// Field ranges and bit positions
`define BOR_F_ADDR      23:0
`define BOR_B_TILED     31
`define BOR_F_W         12:0
`define BOR_F_H         28:16
`define BOR_F_X         12:0
`define BOR_F_Y         28:16
`define BOR_F_OP        3:0
`define BOR_B_LAUNCH    8
`define BOR_B_PAT_MONO  13
`define BOR_B_X_RTL     14
`define BOR_B_Y_BTT     15
`define BOR_F_STRIDE    13:0
`define BOR_F_SRC_CLR   19:16
`define BOR_SRC_MONO    4'h0
`define BOR_F_WIDX      6:2
`define BOR_F_MONO_ALN  4:0
`define BOR_F_BYTE_ALN  1:0
`define BOR_MONO_TOP    3'h7
`define BOR_BYTE_MASK   16'h00ff

`endif

// ### rtl/bor_operand_regs.sv
// Operand register bank of a 2D block-transfer engine: tile store, surface
// bases, sizes, positions, command and source format; feeds the engine.
// Assumes one 50 MHz clock, synchronous inputs and a strobe register port.
`timescale 1ns/100ps
`default_nettype none
`include "bor_defines.svh"

// Function
// - Tile store holds 8x8 pixels: mono words 0-1, 8bpp 0-15, 16bpp 0-31.
// - Mono row n is byte n of words 0/1, leftmost pixel at the MSB.
// - Base registers hold a 24-bit address and a tiled flag in bit 31.
// - Source base used only for screen copies; host copies align from source x.
// - Size registers: width in bits 12:0, height in bits 28:16.
// - Source size applies only to stretch copies; otherwise destination size.
// - Screen copy positions name the corner chosen by the two direction bits.
// - Lines use source position as start and destination position as end.
// - In polygon mode positions track latest left and right vertices.
// - Polygon command with launch bit copies source position into destination.
// - Host copy alignment: mono uses x bits 4:0, colour x bits 1:0.
// - Host copies always run left to right, ignoring the x direction bit.
// - Each later host span alignment adds the source stride to the previous.
// - Command bits 15:14 choose right-to-left and bottom-to-top copying.
// - Command bit 13 selects a monochrome or destination-format tile.
// - Source stride for span alignment is source format bits 13:0.
module bor_operand_regs (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [31:0] reg_rdata_q,
	// Engine events
	input  wire logic        span_next,
	input  wire logic        left_vtx_valid,
	input  wire logic        right_vtx_valid,
	input  wire logic [31:0] vtx_xy,
	// Tile pixel lookup
	input  wire logic [2:0]  pat_x,
	input  wire logic [2:0]  pat_y,
	output var  logic [15:0] pat_pixel_q,
	// Operation
	output var  logic        cmd_start_q,
	output var  logic [3:0]  op_q,
	output var  logic        x_rtl_q,
	output var  logic        y_btt_q,
	output var  logic        pat_mono_q,
	// Surfaces
	output var  logic [23:0] src_addr_q,
	output var  logic        src_tiled_q,
	output var  logic        use_src_base_q,
	output var  logic [23:0] dst_addr_q,
	output var  logic        dst_tiled_q,
	// Rectangle sizes
	output var  logic [12:0] eff_src_w_q,
	output var  logic [12:0] eff_src_h_q,
	output var  logic [12:0] dst_w_q,
	output var  logic [12:0] dst_h_q,
	// Positions and host alignment
	output var  logic [31:0] start_xy_q,
	output var  logic [31:0] end_xy_q,
	output var  logic [4:0]  host_align_q
);
	// ==========================================================
	// Register state
	logic [31:0] src_base_q, dst_base_q, src_size_q, dst_size_q;
	logic [31:0] src_pos_q, dst_pos_q, command_q, src_fmt_q, tile_cfg_q;
	logic [31:0] rd_word;
	logic        rd_tile;
	logic [31:0] tile_word;
	logic        mono_s1_q, deep_s1_q;
	logic [4:0]  lane_s1_q;
	bor_pkg::bor_op_e op_w;

	// Word index of a tile pixel in the current tile format
	function automatic bor_pkg::bor_widx_t tile_idx(input logic mono, input logic deep,
			input logic [2:0] x, input logic [2:0] y);
		if (mono) begin
			tile_idx = {4'h0, y[2]};
		end else if (deep) begin
			tile_idx = {y, x[2:1]};
		end else begin
			tile_idx = {1'b0, y, x[2]};
		end
	endfunction

	// Bit offset of a tile pixel inside its word
	function automatic logic [4:0] tile_lane(input logic mono, input logic deep,
			input logic [2:0] x, input logic [2:0] y);
		if (mono) begin
			tile_lane = {y[1:0], `BOR_MONO_TOP - x};
		end else if (deep) begin
			tile_lane = {x[0], 4'h0};
		end else begin
			tile_lane = {x[1:0], 3'h0};
		end
	endfunction

	// Host alignment field drawn from an x value
	function automatic logic [4:0] host_align(input logic mono, input logic [12:0] x);
		host_align = mono ? x[`BOR_F_MONO_ALN] : {3'h0, x[`BOR_F_BYTE_ALN]};
	endfunction

	function automatic logic is_wr(input logic [7:0] a);
		is_wr = reg_wr && (reg_addr == a);
	endfunction

	wire logic tile_wr   = reg_wr && (reg_addr <= `BOR_A_TILE_LAST);
	wire logic cmd_wr    = reg_wr && (reg_addr == `BOR_A_COMMAND); // Inline: a function would miss strobe changes
	wire logic host_op   = (op_w == bor_pkg::BOR_OP_HOST_COPY) || (op_w == bor_pkg::BOR_OP_HOST_STRCH);
	wire logic src_mono  = (src_fmt_q[`BOR_F_SRC_CLR] == `BOR_SRC_MONO);
	wire logic poly_wcmd = cmd_wr && reg_wdata[`BOR_B_LAUNCH]
		&& (reg_wdata[`BOR_F_OP] == bor_pkg::BOR_OP_POLYGON);
	assign op_w = bor_pkg::bor_op_e'(command_q[`BOR_F_OP]);

	// ==========================================================
	// Plain software registers, reserved bits dropped on write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			src_base_q <= `BOR_RESET_WORD;
			dst_base_q <= `BOR_RESET_WORD;
			src_size_q <= `BOR_RESET_WORD;
			dst_size_q <= `BOR_RESET_WORD;
			command_q  <= `BOR_RESET_WORD;
			src_fmt_q  <= `BOR_RESET_WORD;
			tile_cfg_q <= `BOR_RESET_WORD;
		end else begin
			if (is_wr(`BOR_A_SRC_BASE)) src_base_q <= reg_wdata & `BOR_M_BASE;
			if (is_wr(`BOR_A_DST_BASE)) dst_base_q <= reg_wdata & `BOR_M_BASE;
			if (is_wr(`BOR_A_SRC_SIZE)) src_size_q <= reg_wdata & `BOR_M_SIZE;
			if (is_wr(`BOR_A_DST_SIZE)) dst_size_q <= reg_wdata & `BOR_M_SIZE;
			if (cmd_wr)                 command_q  <= reg_wdata & `BOR_M_COMMAND;
			if (is_wr(`BOR_A_SRC_FMT))  src_fmt_q  <= reg_wdata & `BOR_M_SRC_FMT;
			if (is_wr(`BOR_A_TILE_CFG)) tile_cfg_q <= reg_wdata & `BOR_M_TILE_CFG;
		end
	end

	// Positions; engine vertex updates win over a software write in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			src_pos_q <= `BOR_RESET_WORD;
			dst_pos_q <= `BOR_RESET_WORD;
		end else begin
			if (left_vtx_valid) begin
				src_pos_q <= vtx_xy & `BOR_M_POS;
			end else if (is_wr(`BOR_A_SRC_POS)) begin
				src_pos_q <= reg_wdata & `BOR_M_POS;
			end
			if (right_vtx_valid) begin
				dst_pos_q <= vtx_xy & `BOR_M_POS;
			end else if (poly_wcmd) begin
				dst_pos_q <= src_pos_q;
			end else if (is_wr(`BOR_A_DST_POS)) begin
				dst_pos_q <= reg_wdata & `BOR_M_POS;
			end
		end
	end

	// ==========================================================
	// Operation outputs, refreshed every cycle from command_q; cmd_start_q from the launch write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmd_start_q <= 1'b0;
			op_q        <= 4'h0;
			x_rtl_q     <= 1'b0;
			y_btt_q     <= 1'b0;
			pat_mono_q  <= 1'b0;
		end else begin
			cmd_start_q <= cmd_wr && reg_wdata[`BOR_B_LAUNCH];
			op_q        <= command_q[`BOR_F_OP];
			x_rtl_q     <= command_q[`BOR_B_X_RTL] && !host_op;
			y_btt_q     <= command_q[`BOR_B_Y_BTT];
			pat_mono_q  <= command_q[`BOR_B_PAT_MONO];
		end
	end

	// Surfaces and sizes seen by the engine
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			src_addr_q     <= 24'h0;
			src_tiled_q    <= 1'b0;
			use_src_base_q <= 1'b0;
			dst_addr_q     <= 24'h0;
			dst_tiled_q    <= 1'b0;
			eff_src_w_q    <= 13'h0;
			eff_src_h_q    <= 13'h0;
			dst_w_q        <= 13'h0;
			dst_h_q        <= 13'h0;
		end else begin
			src_addr_q     <= src_base_q[`BOR_F_ADDR];
			src_tiled_q    <= src_base_q[`BOR_B_TILED];
			use_src_base_q <= (op_w == bor_pkg::BOR_OP_SCR_COPY) || (op_w == bor_pkg::BOR_OP_SCR_STRCH);
			dst_addr_q     <= dst_base_q[`BOR_F_ADDR];
			dst_tiled_q    <= dst_base_q[`BOR_B_TILED];
			if ((op_w == bor_pkg::BOR_OP_SCR_STRCH) || (op_w == bor_pkg::BOR_OP_HOST_STRCH)) begin
				eff_src_w_q <= src_size_q[`BOR_F_W];
				eff_src_h_q <= src_size_q[`BOR_F_H];
			end else begin
				eff_src_w_q <= dst_size_q[`BOR_F_W];
				eff_src_h_q <= dst_size_q[`BOR_F_H];
			end
			dst_w_q        <= dst_size_q[`BOR_F_W];
			dst_h_q        <= dst_size_q[`BOR_F_H];
		end
	end

	// Start and end points: copy corners, line segment ends, polygon sides
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			start_xy_q <= `BOR_RESET_WORD;
			end_xy_q   <= `BOR_RESET_WORD;
		end else begin
			start_xy_q <= src_pos_q;
			end_xy_q   <= dst_pos_q;
		end
	end

	// Host span alignment: loaded on a command write, stepped by the stride
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			host_align_q <= 5'h0;
		end else if (cmd_wr) begin
			host_align_q <= host_align(src_mono, src_pos_q[`BOR_F_X]);
		end else if (span_next && host_op) begin
			if (src_mono) begin
				host_align_q <= host_align_q + src_fmt_q[`BOR_F_MONO_ALN];
			end else begin
				host_align_q <= {3'h0, host_align_q[`BOR_F_BYTE_ALN] + src_fmt_q[`BOR_F_BYTE_ALN]};
			end
		end
	end

	// ==========================================================
	// Tile store; a narrow 32-word RAM rather than flops keeps area down
	always_comb begin
		rd_tile = reg_addr <= `BOR_A_TILE_LAST;
		unique case (reg_addr)
			`BOR_A_SRC_BASE: rd_word = src_base_q;
			`BOR_A_DST_BASE: rd_word = dst_base_q;
			`BOR_A_SRC_SIZE: rd_word = src_size_q;
			`BOR_A_DST_SIZE: rd_word = dst_size_q;
			`BOR_A_SRC_POS:  rd_word = src_pos_q;
			`BOR_A_DST_POS:  rd_word = dst_pos_q;
			`BOR_A_COMMAND:  rd_word = command_q;
			`BOR_A_SRC_FMT:  rd_word = src_fmt_q;
			`BOR_A_TILE_CFG: rd_word = tile_cfg_q;
			default:         rd_word = `BOR_RESET_WORD;
		endcase
	end

	bor_tile_mem u_tile (
		.clk         (clk),
		.wr_en       (tile_wr),
		.wr_idx      (reg_addr[`BOR_F_WIDX]),
		.wr_data     (reg_wdata),
		.rda_idx     (tile_idx(command_q[`BOR_B_PAT_MONO], tile_cfg_q[0], pat_x, pat_y)),
		.rda_q       (tile_word),
		.rdb_idx     (reg_addr[`BOR_F_WIDX]),
		.rdb_alt_sel (!rd_tile),
		.rdb_alt     (rd_word),
		.rdb_q       (reg_rdata_q)
	);

	// Lane info registered in the same stage as the one-cycle RAM read
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mono_s1_q <= 1'b0;
			deep_s1_q <= 1'b0;
			lane_s1_q <= 5'h0;
		end else begin
			mono_s1_q <= command_q[`BOR_B_PAT_MONO];
			deep_s1_q <= tile_cfg_q[0];
			lane_s1_q <= tile_lane(command_q[`BOR_B_PAT_MONO], tile_cfg_q[0], pat_x, pat_y);
		end
	end

	// Pixel extraction: two cycles from pat_x/pat_y to pat_pixel_q
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pat_pixel_q <= 16'h0;
		end else if (mono_s1_q) begin
			pat_pixel_q <= {15'h0, tile_word[lane_s1_q]};
		end else if (deep_s1_q) begin
			pat_pixel_q <= 16'((tile_word >> lane_s1_q));
		end else begin
			pat_pixel_q <= 16'((tile_word >> lane_s1_q)) & `BOR_BYTE_MASK;
		end
	end

	// ==========================================================
	// Checks
	base_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst)
		src_base_q[30:24] == 7'h0 && dst_base_q[30:24] == 7'h0)
		else $error("base reserved bits set");
	size_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst)
		(dst_size_q & ~`BOR_M_SIZE) == 32'h0 && (src_size_q & ~`BOR_M_SIZE) == 32'h0)
		else $error("size reserved bits set");
	poly_copy_a: assert property (@(posedge clk) disable iff (sys_rst)
		poly_wcmd && !right_vtx_valid |=> dst_pos_q == $past(src_pos_q))
		else $error("polygon launch did not copy position");
	left_vtx_a: assert property (@(posedge clk) disable iff (sys_rst)
		left_vtx_valid ##1 reg_rd && reg_addr == `BOR_A_SRC_POS && !left_vtx_valid
		|=> reg_rdata_q == ($past(vtx_xy, 2) & `BOR_M_POS))
		else $error("left vertex not readable");
	src_size_a: assert property (@(posedge clk) disable iff (sys_rst)
		op_w == bor_pkg::BOR_OP_SCR_COPY |=> eff_src_w_q == $past(dst_size_q[`BOR_F_W]))
		else $error("plain copy used source size");
	host_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
		host_op |=> !x_rtl_q)
		else $error("host copy ran right to left");
	span_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		span_next && host_op && src_mono && !cmd_wr
		|=> host_align_q == 5'($past(host_align_q) + $past(src_fmt_q[4:0])))
		else $error("span alignment not stepped");
	unmapped_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr > `BOR_A_TILE_CFG |=> reg_rdata_q == 32'h0)
		else $error("unmapped read not zero");
	mono_pix_a: assert property (@(posedge clk) disable iff (sys_rst)
		command_q[`BOR_B_PAT_MONO] && pat_y == 3'h0 && pat_x == 3'h0 ##1 1'b1
		|=> pat_pixel_q[15:1] == 15'h0 && pat_pixel_q[0] == $past(tile_word[7]))
		else $error("mono tile pixel misplaced");
endmodule
`default_nettype wire

// ### rtl/bor_pkg.sv
// Types shared by the blit operand register bank.
// Assumes nothing of its surroundings.
`default_nettype none
package bor_pkg;
	// Engine operations carried in the command word
	typedef enum logic [3:0] {
		BOR_OP_NOP        = 4'h0,
		BOR_OP_SCR_COPY   = 4'h1,
		BOR_OP_SCR_STRCH  = 4'h2,
		BOR_OP_HOST_COPY  = 4'h3,
		BOR_OP_HOST_STRCH = 4'h4,
		BOR_OP_RECT_FILL  = 4'h5,
		BOR_OP_LINE       = 4'h6,
		BOR_OP_POLYLINE   = 4'h7,
		BOR_OP_POLYGON    = 4'h8
	} bor_op_e;
	typedef logic [4:0] bor_widx_t;
endpackage
`default_nettype wire

// ### rtl/bor_tile_mem.sv
// Fill tile store: 32 words of 32 bits, one write port, two registered reads.
// Assumes one clock; port B can load a bypass word instead of the array.
`timescale 1ns/100ps
`default_nettype none
module bor_tile_mem (
	// Clock
	input  wire logic               clk,
	// Write port
	input  wire logic               wr_en,
	input  wire bor_pkg::bor_widx_t wr_idx,
	input  wire logic [31:0]        wr_data,
	// Engine read port
	input  wire bor_pkg::bor_widx_t rda_idx,
	output var  logic [31:0]        rda_q,
	// Software read port with bypass
	input  wire bor_pkg::bor_widx_t rdb_idx,
	input  wire logic               rdb_alt_sel,
	input  wire logic [31:0]        rdb_alt,
	output var  logic [31:0]        rdb_q
);
	// ==========================================================
	// Storage
	logic [31:0] mem [32];

	// Writes; tile content has no reset, as in a plain RAM
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	// Engine read, one cycle latency
	always_ff @(posedge clk) begin
		rda_q <= mem[rda_idx];
	end

	// Software read; bypass keeps the bus answer a single flop
	always_ff @(posedge clk) begin
		rdb_q <= rdb_alt_sel ? rdb_alt : mem[rdb_idx];
	end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the blit operand register bank.
// Assumes the design files under rtl/ are compiled first; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	// ==========================================================
	// Stimulus, observed outputs and score
	logic        clk             = 1'b0;
	logic        sys_rst         = 1'b1;
	logic [7:0]  reg_addr        = 8'h00;
	logic [31:0] reg_wdata       = 32'h00000000;
	logic        reg_wr          = 1'b0;
	logic        reg_rd          = 1'b0;
	logic        span_next       = 1'b0;
	logic        left_vtx_valid  = 1'b0;
	logic        right_vtx_valid = 1'b0;
	logic [31:0] vtx_xy          = 32'h00000000;
	logic [2:0]  pat_x           = 3'h0;
	logic [2:0]  pat_y           = 3'h0;
	logic [31:0] reg_rdata_q;
	logic [15:0] pat_pixel_q;
	logic        cmd_start_q;
	logic [3:0]  op_q;
	logic        x_rtl_q;
	logic        y_btt_q;
	logic        pat_mono_q;
	logic [23:0] src_addr_q;
	logic        src_tiled_q;
	logic        use_src_base_q;
	logic [23:0] dst_addr_q;
	logic        dst_tiled_q;
	logic [12:0] eff_src_w_q;
	logic [12:0] eff_src_h_q;
	logic [12:0] dst_w_q;
	logic [12:0] dst_h_q;
	logic [31:0] start_xy_q;
	logic [31:0] end_xy_q;
	logic [4:0]  host_align_q;
	int          mismatches      = 0;
	int          total_checks    = 0;

	// 50 MHz clock
	always #10 clk = ~clk;

	bor_operand_regs dut (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .span_next(span_next), .left_vtx_valid(left_vtx_valid),
		.right_vtx_valid(right_vtx_valid), .vtx_xy(vtx_xy), .pat_x(pat_x), .pat_y(pat_y),
		.pat_pixel_q(pat_pixel_q), .cmd_start_q(cmd_start_q), .op_q(op_q), .x_rtl_q(x_rtl_q),
		.y_btt_q(y_btt_q), .pat_mono_q(pat_mono_q), .src_addr_q(src_addr_q), .src_tiled_q(src_tiled_q),
		.use_src_base_q(use_src_base_q), .dst_addr_q(dst_addr_q), .dst_tiled_q(dst_tiled_q),
		.eff_src_w_q(eff_src_w_q), .eff_src_h_q(eff_src_h_q), .dst_w_q(dst_w_q), .dst_h_q(dst_h_q),
		.start_xy_q(start_xy_q), .end_xy_q(end_xy_q), .host_align_q(host_align_q)
	);

	// ==========================================================
	// Shared tasks: compare, bus cycles, engine pulses
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data follow the address one cycle later, the strobe unused, so sample just past that edge
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata_q, exp);
	endtask

	task automatic ev(input logic [2:0] which, input logic [31:0] v);
		@(posedge clk);
		vtx_xy <= v;
		{span_next, left_vtx_valid, right_vtx_valid} <= which;
		@(posedge clk);
		{span_next, left_vtx_valid, right_vtx_valid} <= 3'b000;
	endtask

	// Engine-facing copies lag the register by one cycle; two edges cover it
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	// Lookup is pipelined two deep; inputs are held so a later sample is still valid
	task automatic pix(input logic [2:0] x, input logic [2:0] y, input logic [15:0] m, input logic [15:0] exp);
		@(posedge clk);
		pat_x <= x;
		pat_y <= y;
		repeat (3) @(posedge clk);
		#1;
		chk({16'h0000, pat_pixel_q & m}, {16'h0000, exp});
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_masks();
		rd_chk(8'h80, 32'h00000000); // Cleared by reset
		for (int i = 0; i < 6; i++) begin
			wr(8'h80 + 8'(4 * i), 32'hffffffff);
			rd_chk(8'h80 + 8'(4 * i), (i < 2) ? 32'h80ffffff : 32'h1fff1fff); // Spare bits read zero
		end
		wr(8'ha4, 32'h12345678);
		rd_chk(8'ha4, 32'h00000000); // Hole in the map
	endtask

	task automatic t_ops();
		logic [3:0] op;
		logic       strch;
		wr(8'h80, 32'h80123454); // Word-aligned base, as packed 4:2:2 sources need
		wr(8'h84, 32'h00abcdef);
		wr(8'h88, 32'h00400030);
		wr(8'h8c, 32'h00200010);
		// Operations 1 to 8 with both direction bits and the mono tile bit set
		for (int i = 1; i < 9; i++) begin
			op    = 4'(i);
			strch = (op == 4'h2) || (op == 4'h4);
			wr(8'h98, 32'h0000e000 | {28'h0000000, op});
			settle();
			chk(32'(op_q), 32'(op));
			chk(32'(x_rtl_q), 32'(!(op == 4'h3 || op == 4'h4)));
			chk(32'(y_btt_q), 32'h00000001);
			chk(32'(pat_mono_q), 32'h00000001);
			chk(32'(use_src_base_q), 32'(op == 4'h1 || op == 4'h2));
			chk(32'(eff_src_w_q), strch ? 32'h00000030 : 32'h00000010);
			chk(32'(eff_src_h_q), strch ? 32'h00000040 : 32'h00000020);
		end
		chk({src_addr_q, 7'h00, src_tiled_q}, 32'h12345401);
		chk({dst_addr_q, 7'h00, dst_tiled_q}, 32'habcdef00);
		chk({3'h0, dst_w_q, 3'h0, dst_h_q}, 32'h00100020);
	endtask

	task automatic t_host();
		wr(8'h9c, 32'h0000001d); // Mono source, stride 29
		wr(8'h90, 32'h000501f3);
		wr(8'h98, 32'h00004003); // Host copy asking for right to left
		settle();
		chk(32'(host_align_q), 32'h00000013);
		chk(32'(x_rtl_q), 32'h00000000);
		ev(3'b100, 32'h00000000);
		settle();
		chk(32'(host_align_q), 32'h00000010); // Wraps past 31
		ev(3'b100, 32'h00000000);
		settle();
		chk(32'(host_align_q), 32'h0000000d);
		wr(8'h9c, 32'h00ffc006); // Colour source, stride 6
		rd_chk(8'h9c, 32'h00ff0006);
		wr(8'h98, 32'h00000004);
		settle();
		chk(32'(host_align_q), 32'h00000003);
		ev(3'b100, 32'h00000000);
		settle();
		chk(32'(host_align_q), 32'h00000001);
	endtask

	task automatic t_poly();
		int n;
		n = 0;
		wr(8'h90, 32'h00030002); // Topmost, leftmost vertex goes in first
		wr(8'h94, 32'h00090008);
		wr(8'h98, 32'h00000006);
		settle();
		chk(start_xy_q, 32'h00030002);
		chk(end_xy_q, 32'h00090008);
		// Left vertex then a read in the very next cycle, so the readback check sees it
		@(posedge clk);
		vtx_xy         <= 32'hffffffff;
		left_vtx_valid <= 1'b1;
		@(posedge clk);
		left_vtx_valid <= 1'b0;
		reg_addr       <= 8'h90;
		reg_rd         <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata_q, 32'h1fff1fff); // Latest left vertex
		ev(3'b001, 32'h00220011);
		rd_chk(8'h94, 32'h00220011); // Latest right vertex
		wr(8'h98, 32'h00000108);
		// Launch pulse is one cycle wide, wherever it falls in this span
		for (int k = 0; k < 3; k++) begin
			#1;
			n += int'(cmd_start_q === 1'b1);
			@(posedge clk);
		end
		chk(32'(n), 32'h00000001);
		rd_chk(8'h94, 32'h1fff1fff);
		settle();
		chk(end_xy_q, 32'h1fff1fff);
	endtask

	task automatic t_tile();
		wr(8'h00, 32'h00000080); // Row 0, leftmost pixel
		wr(8'h04, 32'h01000000); // Row 7, rightmost pixel
		wr(8'h0c, 32'h44332211);
		wr(8'h7c, 32'hbeefcafe);
		rd_chk(8'h0c, 32'h44332211);
		wr(8'h98, 32'h00002005);
		pix(3'h0, 3'h0, 16'h0001, 16'h0001);
		pix(3'h1, 3'h0, 16'h0001, 16'h0000);
		pix(3'h7, 3'h7, 16'h0001, 16'h0001);
		pix(3'h0, 3'h7, 16'h0001, 16'h0000);
		wr(8'h98, 32'h00000005);
		wr(8'ha0, 32'h00000000);
		pix(3'h0, 3'h0, 16'h00ff, 16'h0080);
		pix(3'h4, 3'h1, 16'h00ff, 16'h0011);
		pix(3'h7, 3'h1, 16'h00ff, 16'h0044);
		wr(8'ha0, 32'h00000001);
		pix(3'h6, 3'h0, 16'hffff, 16'h2211);
		pix(3'h7, 3'h7, 16'hffff, 16'hbeef); // Last word of the store
	endtask

	// Second reset in mid-run clears the registers again; tile words are not reset
	task automatic t_reset();
		@(posedge clk);
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		rd_chk(8'h90, 32'h00000000);
		settle();
		chk({8'h00, src_addr_q}, 32'h00000000);
	endtask

	// ==========================================================
	// Verdict and run control
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Whole sequence needs well under a thousand cycles
	initial begin
		#400000;
		mismatches++;
		close_out();
	end

	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		// Tile words are loaded before any mono command, so mono lookups never see unknowns
		t_masks();
		t_tile();
		t_ops();
		t_host();
		t_poly();
		t_reset();
		close_out();
	end
endmodule
`default_nettype wire
